// file: hdl/adisp_top.sv
// Serial slave front end: wake detection, bit and byte handling, address match,
// word address decode and loading of command bytes toward the command engine.
// Assumes SCL and SDA come from pins; EXEC_DONE and CMD_READY share SYS_CLK.
`timescale 1ns/1ps
`default_nettype none

module adisp_top #(
    parameter int          WHI_CYC  = adisp_pkg::WHI_CYC,
    parameter logic [15:0] STAT_CRC = 16'h0000
) (
    // Clock, reset and enable.
    input  wire logic                   SYS_CLK,
    input  wire logic                   RST_N,
    input  wire logic                   CLK_EN,
    // Serial pins.
    input  wire logic                   SCL_IN,
    input  wire logic                   SDA_IN,
    output var  logic                   SDA_OUT,
    output var  logic                   SDA_OE,
    // Configuration.
    input  wire logic [6:0]             DEV_ADDR,
    // Command byte stream.
    output var  logic                   CMD_VALID,
    output var  adisp_pkg::adisp_byte_t CMD_BYTE,
    input  wire logic                   CMD_READY,
    // Engine handshake and power status.
    output var  logic                   EXEC_START,
    input  wire logic                   EXEC_DONE,
    output var  logic                   BUSY,
    output var  logic                   AWAKE,
    output var  logic                   SLEEP_RST,
    output var  logic                   IDLE_ENTER,
    output var  logic                   PTR_RST
);

    localparam int TMAX = (WHI_CYC > adisp_pkg::WLO_CYC) ? WHI_CYC : adisp_pkg::WLO_CYC;
    localparam int TW   = $clog2(TMAX + 1);

    logic [2:0]             scl_r;
    logic [2:0]             sda_r;
    adisp_pkg::adisp_pwr_t  pwr_r;
    logic [TW-1:0]          tmr_r;
    adisp_pkg::adisp_link_t lst_r;
    adisp_pkg::adisp_kind_t kind_r;
    logic [3:0]             bitcnt_r;
    logic [7:0]             shift_r;
    logic                   oe_r;
    logic                   rd_r;
    logic                   mack_r;
    logic [2:0]             rd_ptr_r;
    logic [7:0]             wa_r;
    logic                   wa_v_r;
    logic [6:0]             rcvd_r;
    logic [7:0]             len_r;
    logic                   busy_r;
    logic                   stat_v_r;
    logic                   start_p_r;
    logic                   sleep_p_r;
    logic                   idle_p_r;
    logic                   ptr_p_r;
    logic                   awake_o_r;
    adisp_pkg::adisp_byte_t out_r;
    adisp_pkg::adisp_byte_t skid_r;
    logic                   out_v_r;
    logic                   skid_v_r;

    // Only the second and third stages are read; the first stage is metastable-prone.
    wire scl      = scl_r[1];
    wire sda      = sda_r[1];
    wire awake    = (pwr_r == adisp_pkg::P_AWAKE);
    wire scl_rise = scl & ~scl_r[2];
    wire scl_fall = ~scl & scl_r[2];
    wire start_ev = awake & scl & scl_r[2] & sda_r[2] & ~sda;
    wire stop_ev  = awake & scl & scl_r[2] & ~sda_r[2] & sda;
    wire decide   = awake & (lst_r == adisp_pkg::L_RX) & (bitcnt_r == adisp_pkg::BYTE_BITS)
                    & scl_fall;
    wire addr_ok  = (shift_r[7:1] == DEV_ADDR);
    wire complete = (rcvd_r != 7'h00) & ({1'b0, rcvd_r} >= len_r);
    wire accept   = (kind_r == adisp_pkg::K_DATA) & wa_v_r & (wa_r == adisp_pkg::WA_CMD)
                    & ~busy_r & ~complete & (rcvd_r < adisp_pkg::BUF_BYTES) & ~skid_v_r;
    wire push     = decide & accept;
    wire stop_ok  = stop_ev & ~busy_r & wa_v_r;
    wire go_sleep = stop_ok & (wa_r == adisp_pkg::WA_SLEEP);
    wire go_idle  = stop_ok & (wa_r == adisp_pkg::WA_IDLE);
    wire pop      = out_v_r & CMD_READY;
    wire [7:0] nrcvd = {1'b0, rcvd_r} + 8'h01;
    wire last_b   = (rcvd_r == 7'h00) ? (shift_r <= 8'h01) : (nrcvd == len_r);
    wire word_rst = decide & (kind_r == adisp_pkg::K_WORD) & (shift_r == adisp_pkg::WA_RESET);

    logic ack_now;
    always_comb
    begin
        unique case (kind_r)
            adisp_pkg::K_ADDR: ack_now = addr_ok & ~(shift_r[0] & busy_r);
            adisp_pkg::K_WORD: ack_now = 1'b1;
            default:           ack_now = accept;
        endcase
    end

    // Byte offered to a reading master; a partial command reads as a floating bus.
    function automatic logic [7:0] rd_byte(input logic [2:0] ptr, input logic sv);
        logic [7:0] b;
        b = adisp_pkg::FLOAT_BYTE;
        if (sv && ptr < adisp_pkg::STAT_LEN)
        begin
            unique case (ptr[1:0])
                2'h0: b = adisp_pkg::STAT_COUNT;
                2'h1: b = adisp_pkg::STAT_WAKE;
                2'h2: b = STAT_CRC[7:0];
                2'h3: b = STAT_CRC[15:8];
            endcase
        end
        return b;
    endfunction

    wire       rd_sv  = stat_v_r & (rcvd_r == 7'h00);
    wire [7:0] rd_now = rd_byte(rd_ptr_r, rd_sv);

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            scl_r <= 3'h7;
            sda_r <= 3'h7;
        end
        else if (CLK_EN)
        begin
            scl_r <= {scl_r[1:0], SCL_IN};
            sda_r <= {sda_r[1:0], SDA_IN};
        end
    end

    // Power state; wake detection looks only at SDA, SCL enters only through the stop that ends a sleep or idle word.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pwr_r <= adisp_pkg::P_SLEEP;
            tmr_r <= '0;
        end
        else if (CLK_EN)
        begin
            unique case (pwr_r)
                adisp_pkg::P_SLEEP, adisp_pkg::P_IDLE:
                begin
                    if (sda)
                        tmr_r <= '0;
                    else if (tmr_r >= TW'(adisp_pkg::WLO_CYC))
                    begin
                        pwr_r <= adisp_pkg::P_WAKEHI;
                        tmr_r <= '0;
                    end
                    else
                        tmr_r <= tmr_r + 1'b1;
                end
                adisp_pkg::P_WAKEHI:
                begin
                    if (tmr_r >= TW'(WHI_CYC - 1))
                    begin
                        pwr_r <= adisp_pkg::P_AWAKE;
                        tmr_r <= '0;
                    end
                    else
                        tmr_r <= tmr_r + 1'b1;
                end
                adisp_pkg::P_AWAKE:
                begin
                    tmr_r <= '0;
                    if (go_sleep)
                        pwr_r <= adisp_pkg::P_SLEEP;
                    else if (go_idle)
                        pwr_r <= adisp_pkg::P_IDLE;
                end
            endcase
        end
    end

    // Bit and byte engine; SDA is only ever pulled low.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            lst_r    <= adisp_pkg::L_WAIT;
            kind_r   <= adisp_pkg::K_ADDR;
            bitcnt_r <= 4'h0;
            shift_r  <= 8'h00;
            oe_r     <= 1'b0;
            rd_r     <= 1'b0;
            mack_r   <= 1'b0;
            rd_ptr_r <= 3'h0;
        end
        else if (CLK_EN)
        begin
            if (!awake)
            begin
                lst_r    <= adisp_pkg::L_WAIT;
                oe_r     <= 1'b0;
                rd_ptr_r <= 3'h0;
            end
            else if (start_ev)
            begin
                lst_r    <= adisp_pkg::L_RX;
                kind_r   <= adisp_pkg::K_ADDR;
                bitcnt_r <= 4'h0;
                oe_r     <= 1'b0;
                rd_r     <= 1'b0;
            end
            else if (stop_ev)
            begin
                lst_r <= adisp_pkg::L_WAIT;
                oe_r  <= 1'b0;
            end
            else
            begin
                if (word_rst && !busy_r)
                    rd_ptr_r <= 3'h0;
                unique case (lst_r)
                    adisp_pkg::L_WAIT: oe_r <= 1'b0;
                    adisp_pkg::L_RX:
                    begin
                        if (scl_rise)
                        begin
                            shift_r  <= {shift_r[6:0], sda};
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end
                        else if (decide)
                        begin
                            oe_r <= ack_now;
                            rd_r <= (kind_r == adisp_pkg::K_ADDR) & shift_r[0];
                            if (kind_r == adisp_pkg::K_ADDR && !ack_now)
                                lst_r <= adisp_pkg::L_WAIT;
                            else
                                lst_r <= adisp_pkg::L_ACK;
                        end
                    end
                    adisp_pkg::L_ACK:
                    begin
                        if (scl_fall)
                        begin
                            bitcnt_r <= 4'h0;
                            if (rd_r)
                            begin
                                shift_r  <= rd_now;
                                oe_r     <= ~rd_now[7];
                                lst_r    <= adisp_pkg::L_TX;
                                rd_ptr_r <= (rd_ptr_r == adisp_pkg::STAT_LEN) ? rd_ptr_r
                                            : rd_ptr_r + 3'h1;
                            end
                            else
                            begin
                                oe_r   <= 1'b0;
                                lst_r  <= adisp_pkg::L_RX;
                                kind_r <= (kind_r == adisp_pkg::K_ADDR) ? adisp_pkg::K_WORD
                                          : adisp_pkg::K_DATA;
                            end
                        end
                    end
                    adisp_pkg::L_TX:
                    begin
                        if (scl_rise)
                            bitcnt_r <= bitcnt_r + 4'h1;
                        else if (scl_fall)
                        begin
                            if (bitcnt_r == adisp_pkg::BYTE_BITS)
                            begin
                                oe_r  <= 1'b0;
                                lst_r <= adisp_pkg::L_TXACK;
                            end
                            else
                            begin
                                shift_r <= {shift_r[6:0], 1'b1};
                                oe_r    <= ~shift_r[6];
                            end
                        end
                    end
                    adisp_pkg::L_TXACK:
                    begin
                        if (scl_rise)
                            mack_r <= ~sda;
                        else if (scl_fall)
                        begin
                            lst_r    <= mack_r ? adisp_pkg::L_TX : adisp_pkg::L_WAIT;
                            bitcnt_r <= 4'h0;
                            if (mack_r)
                            begin
                                shift_r  <= rd_now;
                                oe_r     <= ~rd_now[7];
                                rd_ptr_r <= (rd_ptr_r == adisp_pkg::STAT_LEN) ? rd_ptr_r
                                            : rd_ptr_r + 3'h1;
                            end
                        end
                    end
                    default: lst_r <= adisp_pkg::L_WAIT;
                endcase
            end
        end
    end

    // Command bookkeeping: word address, block length, busy and pulses.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wa_r      <= 8'h00;
            wa_v_r    <= 1'b0;
            rcvd_r    <= 7'h00;
            len_r     <= 8'h00;
            busy_r    <= 1'b0;
            stat_v_r  <= 1'b0;
            start_p_r <= 1'b0;
            sleep_p_r <= 1'b0;
            idle_p_r  <= 1'b0;
            ptr_p_r   <= 1'b0;
        end
        else if (CLK_EN)
        begin
            start_p_r <= 1'b0;
            sleep_p_r <= go_sleep;
            idle_p_r  <= go_idle;
            ptr_p_r   <= word_rst & ~busy_r;
            if (pwr_r == adisp_pkg::P_WAKEHI)
                stat_v_r <= 1'b1;
            if (!awake || go_sleep || go_idle)
            begin
                wa_v_r <= 1'b0;
                rcvd_r <= 7'h00;
                len_r  <= 8'h00;
            end
            else
            begin
                if (start_ev)
                    wa_v_r <= 1'b0;
                else if (decide && kind_r == adisp_pkg::K_WORD)
                begin
                    wa_r   <= shift_r;
                    wa_v_r <= 1'b1;
                end
                if (word_rst && !busy_r)
                begin
                    rcvd_r <= 7'h00;
                    len_r  <= 8'h00;
                end
                else if (push)
                begin
                    rcvd_r <= rcvd_r + 7'h01;
                    if (rcvd_r == 7'h00)
                        len_r <= shift_r;
                end
                else if (busy_r && EXEC_DONE)
                begin
                    rcvd_r <= 7'h00;
                    len_r  <= 8'h00;
                end
                if (busy_r && EXEC_DONE)
                    busy_r <= 1'b0;
                else if (stop_ev && !busy_r && complete && !go_sleep && !go_idle)
                begin
                    busy_r    <= 1'b1;
                    start_p_r <= 1'b1;
                    stat_v_r  <= 1'b0;
                end
            end
        end
    end

    // Two-entry buffer; when the skid entry is full further bytes are refused on the bus.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            out_r    <= '0;
            skid_r   <= '0;
            out_v_r  <= 1'b0;
            skid_v_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (go_sleep || go_idle)
            begin
                out_v_r  <= 1'b0;
                skid_v_r <= 1'b0;
            end
            else if (pop || !out_v_r)
            begin
                if (skid_v_r)
                begin
                    out_r    <= skid_r;
                    skid_v_r <= 1'b0;
                end
                else
                begin
                    out_r   <= '{last: last_b, data: shift_r};
                    out_v_r <= push;
                end
            end
            else if (push)
            begin
                skid_r   <= '{last: last_b, data: shift_r};
                skid_v_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            awake_o_r <= 1'b0;
        else if (CLK_EN)
            awake_o_r <= awake;
    end

    assign SDA_OUT    = 1'b0;
    assign SDA_OE     = oe_r;
    assign CMD_VALID  = out_v_r;
    assign CMD_BYTE   = out_r;
    assign EXEC_START = start_p_r;
    assign BUSY       = busy_r;
    assign AWAKE      = awake_o_r;
    assign SLEEP_RST  = sleep_p_r;
    assign IDLE_ENTER = idle_p_r;
    assign PTR_RST    = ptr_p_r;

    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    quiet_unawake_a: assert property (!awake |-> !oe_r)
        else $error("SDA pulled while not awake");
    wake_exit_a: assert property (CLK_EN && !awake && pwr_r != adisp_pkg::P_WAKEHI && !sda
        && tmr_r >= TW'(adisp_pkg::WLO_CYC) |=> pwr_r == adisp_pkg::P_WAKEHI)
        else $error("wake not taken after long low");
    no_rewake_a: assert property (CLK_EN && awake |=> pwr_r != adisp_pkg::P_WAKEHI)
        else $error("awake device reentered wake");
    start_take_a: assert property (CLK_EN && start_ev |=> lst_r == adisp_pkg::L_RX
        && bitcnt_r == 4'h0 && kind_r == adisp_pkg::K_ADDR)
        else $error("start not taken");
    busy_read_a: assert property (CLK_EN && decide && kind_r == adisp_pkg::K_ADDR
        && shift_r[0] && busy_r |=> !oe_r && lst_r == adisp_pkg::L_WAIT)
        else $error("read address acked while busy");
    exec_go_a: assert property (CLK_EN && stop_ev && !busy_r && complete && !go_sleep
        && !go_idle |=> busy_r && EXEC_START)
        else $error("complete block did not start");
    sleep_word_a: assert property (CLK_EN && go_sleep |=> pwr_r == adisp_pkg::P_SLEEP
        && SLEEP_RST && rcvd_r == 7'h00)
        else $error("sleep word not honoured");
    idle_word_a: assert property (CLK_EN && go_idle |=> pwr_r == adisp_pkg::P_IDLE
        && IDLE_ENTER && !SLEEP_RST)
        else $error("idle word not honoured");
    overflow_nack_a: assert property (CLK_EN && decide && kind_r == adisp_pkg::K_DATA
        && (rcvd_r >= adisp_pkg::BUF_BYTES || complete) |=> !oe_r)
        else $error("byte beyond limit acked");
    addr_ack_a: assert property (CLK_EN && decide && kind_r == adisp_pkg::K_ADDR
        && !addr_ok |=> !oe_r ##1 !oe_r)
        else $error("foreign address acked");

endmodule

`default_nettype wire

// file: hdl/adisp_pkg.sv
// Shared constants and types for the serial slave front end.
// Assumes a single system clock at the rate given by CLK_NS.
package adisp_pkg;

    // System clock period in ns.
    localparam int CLK_NS = 25;

    // Least low time on SDA that counts as a wake, and the settle delay after it.
    localparam int WAKE_LOW_NS  = 60000;
    localparam int WAKE_HIGH_US = 2500;
    localparam int WLO_CYC = (WAKE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WHI_CYC = (WAKE_HIGH_US * 1000 + CLK_NS - 1) / CLK_NS;

    // Word address functions.
    localparam logic [7:0] WA_RESET = 8'h00;
    localparam logic [7:0] WA_SLEEP = 8'h01;
    localparam logic [7:0] WA_IDLE  = 8'h02;
    localparam logic [7:0] WA_CMD   = 8'h03;

    // Input buffer capacity in bytes.
    localparam logic [6:0] BUF_BYTES = 7'h54;

    // Status block offered after wake.
    localparam logic [7:0] STAT_COUNT = 8'h04;
    localparam logic [7:0] STAT_WAKE  = 8'h11;
    localparam logic [7:0] FLOAT_BYTE = 8'hff;
    localparam logic [2:0] STAT_LEN   = 3'h4;

    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [1:0] {
        P_SLEEP  = 2'b00,
        P_WAKEHI = 2'b01,
        P_AWAKE  = 2'b10,
        P_IDLE   = 2'b11
    } adisp_pwr_t;

    typedef enum logic [2:0] {
        L_WAIT  = 3'b000,
        L_RX    = 3'b001,
        L_ACK   = 3'b010,
        L_TX    = 3'b011,
        L_TXACK = 3'b100
    } adisp_link_t;

    typedef enum logic [1:0] {
        K_ADDR = 2'b00,
        K_WORD = 2'b01,
        K_DATA = 2'b10
    } adisp_kind_t;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } adisp_byte_t;

endpackage

// file: dv/adisp_master.sv
// Behavioural bus master: drives SCL and pulls the shared SDA wire low.
// Assumes the bench resolves the open-drain SDA wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module adisp_master (
    // Bus pins.
    output var  logic scl,
    output var  logic sda_pull,
    input  wire logic sda
);
    localparam int Q = 50;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // SCL stays high so the long low cannot be read as data bits.
    // Pins move by non-blocking assignment, so a change on a system clock edge samples cleanly.
    task automatic wake();
        sda_pull <= 1'b1;
        #62000;
        sda_pull <= 1'b0;
        #(2*Q);
    endtask
    // SDA moves only while SCL is low, and SCL is always driven.
    task automatic clk_bit(input logic v, output logic r);
        #Q sda_pull <= !v;
        #Q scl <= 1'b1;
        #Q r = sda;
        #Q scl <= 1'b0;
    endtask
    task automatic start();
        sda_pull <= 1'b0;
        #Q scl <= 1'b1;
        #(2*Q) sda_pull <= 1'b1;
        #(2*Q) scl <= 1'b0;
    endtask
    // The long tail lets the pulses that a stop triggers settle before anyone looks.
    task automatic stop();
        #Q sda_pull <= 1'b1;
        #Q scl <= 1'b1;
        #(2*Q) sda_pull <= 1'b0;
        #(4*Q);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    // Released for every data bit; the last byte is refused to end the block.
    task automatic get_byte(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, b[i]);
        clk_bit(!more, r);
    endtask
endmodule
`default_nettype wire

// file: dv/test_adisp_top.sv
// Self-checking bench for the serial slave front end.
// Assumes the package, the design and the master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_adisp_top;
    localparam logic [6:0]  ADDR = 7'h64;
    localparam logic [15:0] CRC  = 16'h5aa5;
    logic                   sys_clk, rst_n, clk_en, cmd_ready, exec_done;
    logic                   scl, sda_pull, sda_oe, sda_out, cmd_valid, busy, awake;
    logic                   exec_start, sleep_rst, idle_enter, ptr_rst, ok;
    wire  logic             sda;
    adisp_pkg::adisp_byte_t cmd_byte;
    adisp_pkg::adisp_byte_t exp_q[$];
    int                     mismatches, n_checks, n_exec, n_sleep, n_idle, n_ptr, seed;
    logic [3:0]             acks;
    logic [31:0]            rdat;
    logic [7:0]             d1, d2, d3;

    assign sda = !(sda_pull || (sda_oe && !sda_out));
    always #12.5 sys_clk = !sys_clk;

    adisp_top #(.WHI_CYC(200), .STAT_CRC(CRC)) dut (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(clk_en),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .DEV_ADDR(ADDR), .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte),
        .CMD_READY(cmd_ready), .EXEC_START(exec_start), .EXEC_DONE(exec_done),
        .BUSY(busy), .AWAKE(awake), .SLEEP_RST(sleep_rst),
        .IDLE_ENTER(idle_enter), .PTR_RST(ptr_rst));
    adisp_master m (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] b, input int n, output logic [3:0] a);
        a = 4'h0;
        m.start();
        for (int i = 0; i < n; i++)
            m.put_byte(b[31-8*i -: 8], a[3-i]);
        m.stop();
    endtask
    task automatic rd(input int n, output logic a, output logic [31:0] d);
        d = 32'h0;
        m.start();
        m.put_byte({ADDR, 1'b1}, a);
        for (int i = 0; i < n && a; i++)
            m.get_byte(i < n - 1, d[31-8*i -: 8]);
        m.stop();
    endtask
    task automatic wait_awake();
        for (int i = 0; i < 400 && awake !== 1'b1; i++)
            @(posedge sys_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Results are compared as the stream hands them over, oldest note first.
    always @(posedge sys_clk)
    begin
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
            check({23'h0, cmd_byte}, {23'h0, exp_q.pop_front()});
        n_exec += exec_start;
        n_sleep += sleep_rst;
        n_idle += idle_enter;
        n_ptr += ptr_rst;
    end

    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        cmd_ready = 1'b1;
        exec_done = 1'b0;
        seed = 32'h9a19cdf0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1000;
        wr({ADDR, 1'b0, 24'h030000}, 2, acks);
        check(acks, 4'h0);
        m.wake();
        check(awake, 1'b0);
        wait_awake();
        check(awake, 1'b1);
        m.wake();
        rd(4, ok, rdat);
        check(ok, 1'b1);
        check(rdat, {8'h04, 8'h11, CRC[7:0], CRC[15:8]});
        wr({ADDR ^ 7'h01, 1'b0, 24'h030000}, 2, acks);
        check(acks, 4'h0);
        $display("test wake done");
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        d3 = 8'($random(seed));
        @(posedge sys_clk) cmd_ready <= 1'b0;
        exp_q.push_back('{1'b0, 8'h03});
        exp_q.push_back('{1'b0, d1});
        wr({ADDR, 1'b0, 8'h03, 8'h03, d1}, 4, acks);
        check(acks, 4'hf);
        wr({ADDR, 1'b0, 8'h03, d2, 8'h00}, 3, acks);
        check({acks, 3'h0, busy}, 8'hc0);
        @(posedge sys_clk) cmd_ready <= 1'b1;
        exp_q.push_back('{1'b1, d2});
        wr({ADDR, 1'b0, 8'h03, d2, d3}, 4, acks);
        check(acks, 4'he);
        check({busy, n_exec[3:0]}, 5'h11);
        rd(1, ok, rdat);
        check(ok, 1'b0);
        @(posedge sys_clk) exec_done <= 1'b1;
        @(posedge sys_clk) exec_done <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(1, ok, rdat);
        check({busy, ok}, 2'h1);
        check(exp_q.size(), 0);
        $display("test stream done");
        wr({ADDR, 1'b0, 24'h0}, 2, acks);
        check({acks[3:2], n_ptr[3:0]}, 6'h31);
        wr({ADDR, 1'b0, 8'h01, 16'h0}, 2, acks);
        check({awake, n_sleep[3:0]}, 5'h01);
        wr({ADDR, 1'b0, 24'h030000}, 2, acks);
        check(acks, 4'h0);
        m.wake();
        wait_awake();
        wr({ADDR, 1'b0, 8'h02, 16'h0}, 2, acks);
        check({awake, n_idle[3:0]}, 5'h01);
        rd(1, ok, rdat);
        check(ok, 1'b0);
        @(posedge sys_clk) clk_en <= 1'b0;
        m.wake();
        repeat (300) @(posedge sys_clk);
        check(awake, 1'b0);
        @(posedge sys_clk) clk_en <= 1'b1;
        $display("test power done");
        print_verdict();
    end

    initial
    begin
        #2000000;
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
